// file: bench/vvs_video_src.sv
// stand-in composite video source with scripted line shapes
`timescale 1ns/10ps
module vvs_video_src
  import vvs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] mode,
  input  wire vvs_vid_t   lvl,
  output var  vvs_vid_t   vid
);
  logic [2:0] mode_q;   // mode seen last cycle
  logic [5:0] pos;      // place in a 64-cycle line
  logic [5:0] next_pos; // restarts when the shape changes
  vvs_vid_t   next_vid; // level of the chosen shape

  // shapes: 0 raw level, 1 line, 2 equalizing, 3 serrated, 4 long sync
  always_comb
  begin
    next_pos = (mode != mode_q) ? 6'h00 : pos + 6'h01;
    case (mode)
      3'h1:    next_vid = (next_pos < 6'h05) ? 8'h10 :
                          (next_pos[5] ? 8'hA0 : 8'h40);
      3'h2:    next_vid = (next_pos[4:0] < 5'h02) ? 8'h10 : 8'h40;
      3'h3:    next_vid = (next_pos[4:0] < 5'h1C) ? 8'h10 : 8'h40;
      3'h4:    next_vid = 8'h10;
      default: next_vid = lvl;
    endcase
  end

  // register the source outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= 3'h0;
      pos    <= 6'h00;
      vid    <= 8'h40;
    end
    else
    begin
      mode_q <= mode;
      pos    <= next_pos;
      vid    <= next_vid;
    end
  end
endmodule

// file: bench/vvs_vsync_extract_tb.sv
// self-checking bench for the vertical sync extractor
`timescale 1ns/10ps
module vvs_vsync_extract_tb
  import vvs_pkg::*;
;
  logic        clk;        // 10 MHz system clock
  logic        rst_n;      // async reset, active low
  logic [2:0]  mode;       // source shape
  vvs_vid_t    lvl;        // raw level for shape 0
  vvs_vid_t    vid_in;     // source into device
  vvs_vid_t    rset_code;  // resistor setting code
  vvs_lvl_t    ser_thr;    // serration threshold count
  vvs_lvl_t    dft_thr;    // default threshold count
  logic        csync_out;  // sliced sync
  logic        vsync_out;  // vertical pulse
  logic        field_clk_out; // field flop clock
  logic [15:0] cyc = 16'h0000; // free cycle count
  logic [15:0] t_rise;     // cycle of last pulse start
  logic [15:0] t_len;      // length of last pulse
  logic [15:0] t_edge;     // cycle of trigger edge at input
  logic [3:0]  n_rise;     // pulses since reset
  logic        fclk_bad;   // field clock out of place
  logic        v_d;        // vsync one cycle ago
  vvs_vid_t    vid_q;      // source one cycle ago
  int          err_total;  // mismatches
  int          n_compared; // comparisons

  always #50 clk = ~clk;

  vvs_vsync_extract dut
  (
    .clk                 (clk),
    .rst_n               (rst_n),
    .vid_in              (vid_in),
    .rset_code           (rset_code),
    .serration_threshold (ser_thr),
    .default_threshold   (dft_thr),
    .csync_out           (csync_out),
    .vsync_out           (vsync_out),
    .field_clk_out       (field_clk_out)
  );

  vvs_video_src src
  (
    .clk   (clk),
    .rst_n (rst_n),
    .mode  (mode),
    .lvl   (lvl),
    .vid   (vid_in)
  );

  // measure pulse start, width and count against the input edge
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      n_rise   <= 4'h0;
      t_edge   <= 16'h0000;
      t_rise   <= 16'h0000;
      t_len    <= 16'h0000;
      fclk_bad <= 1'b0;
      v_d      <= 1'b0;
    end
    else
    begin
      cyc   <= cyc + 16'h0001;
      v_d   <= vsync_out;
      vid_q <= vid_in;
      if (vsync_out && !v_d)
      begin
        t_rise <= cyc;
        n_rise <= n_rise + 4'h1;
      end
      if (!vsync_out && v_d)
        t_len <= cyc - t_rise;
      // field clock only in the first pulse cycle
      if (field_clk_out !== (vsync_out && !v_d))
        fclk_bad <= 1'b1;
      // first serration end, or first tip of a long sync
      if (t_edge == 16'h0000 && ((mode == 3'h3 && vid_q == 8'h10 &&
          vid_in != 8'h10) || (mode == 3'h4 && vid_in == 8'h10)))
        t_edge <= cyc;
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %0h", $time, what, got);
    end
  endtask

  task automatic chk_rng(input logic [15:0] got, lo, hi, input string what);
    n_compared++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %0h", $time, what, got);
    end
  endtask

  // reset for five cycles, then release with a source shape
  task automatic restart(input logic [2:0] m);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({13'h0, csync_out, vsync_out, field_clk_out}, 16'h0000, "reset");
    @(posedge clk);
    rst_n <= 1'b1;
    mode  <= m;
  endtask

  // slice sits a fixed offset above the tip, for two amplitudes
  task automatic t_csync;
    vvs_vid_t tips [2] = '{8'h10, 8'h40};
    vvs_vid_t offs [4] = '{8'h00, 8'h06, 8'h07, 8'hB0};
    foreach (tips[i])
    begin
      restart(3'h0);
      lvl <= tips[i];
      repeat (3) @(posedge clk);
      foreach (offs[j])
      begin
        @(posedge clk) lvl <= tips[i] + offs[j];
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, csync_out}, {15'h0, offs[j] < 8'h07}, "csync");
      end
    end
    $display("csync test done");
  endtask

  // lines and equalizing stay quiet, first serration starts the pulse
  task automatic t_vert(input vvs_vid_t r);
    logic [15:0] per;
    per = {4'h0, r, 4'h0} + 16'h0010;
    restart(3'h1);
    rset_code <= r;
    repeat (256) @(posedge clk);
    mode <= 3'h2;
    repeat (384) @(posedge clk);
    chk({12'h0, n_rise}, 16'h0000, "early");
    mode <= 3'h3;
    repeat (96) @(posedge clk);
    mode <= 3'h2;
    repeat (per * 16'h0008 + 16'h000A) @(posedge clk);
    chk_rng(t_rise - t_edge, 16'h0002, 16'h0003, "start");
    chk(t_len, per * 16'h0008 + 16'h0001, "width");
    chk({12'h0, n_rise}, 16'h0001, "count");
    chk({15'h0, fclk_bad}, 16'h0000, "field clock");
    $display("serration test done");
  endtask

  // long sync with no serration: default count starts the pulse
  task automatic t_dflt(input vvs_vid_t r, input vvs_lvl_t d);
    logic [15:0] per;
    logic [15:0] rise;
    per  = {4'h0, r, 4'h0} + 16'h0010;
    rise = {4'h0, d} / {11'h000, {1'b0, ~r[7:4]} + 5'h01};
    restart(3'h4);
    rset_code <= r;
    dft_thr   <= d;
    repeat (per * 16'h0008 + rise + 16'h0010) @(posedge clk);
    chk_rng(t_rise - t_edge, rise + 16'h0001, rise + 16'h0004, "dft");
    chk(t_len, per * 16'h0008 + 16'h0001, "dft width");
    chk({12'h0, n_rise}, 16'h0001, "dft count");
    $display("default test done");
  endtask

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    mode       = 3'h0;
    lvl        = 8'h40;
    rset_code  = 8'h00;
    ser_thr    = 12'h0C0;
    dft_thr    = 12'h300;
    err_total  = 0;
    n_compared = 0;
    t_csync;
    t_vert(8'h00);
    t_vert(8'h80);
    t_dflt(8'h00, 12'h300);
    t_dflt(8'h80, 12'h300);
    t_dflt(8'h00, 12'h200);
    final_report;
  end

  // the run needs about thirty-five thousand cycles, mostly the two
  // slow-oscillator pulses; stop a hang at fifty thousand
  initial
  begin
    #5000000;
    err_total++;
    final_report;
  end
endmodule

// file: pkg/vvs_osc_if.sv
// link between the pulse latch and the gated oscillator divider
`timescale 1ns/10ps
interface vvs_osc_if;
  import vvs_pkg::*;

  logic     run;     // oscillator enable, high while latch is set
  vvs_per_t period;  // cycles per oscillator tick
  logic     tick;    // one-cycle pulse per oscillator cycle
  logic     done;    // one-cycle pulse after eight oscillator cycles

  modport ctl
  (
    output run,
    output period,
    input  tick,
    input  done
  );

  modport osc
  (
    input  run,
    input  period,
    output tick,
    output done
  );
endinterface

// file: pkg/vvs_params.svh
// constants for the vertical sync extractor: widths, offsets, counts
`ifndef VVS_PARAMS_SVH
`define VVS_PARAMS_SVH

// system clock period in ns (10 MHz)
`define VVS_CLK_NS       100
// video sample width and integrator width
`define VVS_VID_W        8
`define VVS_LVL_W        12
// slice offset above the clamped tip, about 70 mV at 10 mV per code
`define VVS_SLICE_OFS    8'h07
// clamp reset value: top of range, pulled down by the first tip
`define VVS_CLAMP_RST    8'hFF
// clock cycles between single-code upward leaks of the clamp
`define VVS_LEAK_CYC     16'h0040
// integrator ceiling, reset value and discharge step per cycle
`define VVS_LVL_MAX      12'hFFF
`define VVS_LVL_RST      12'h000
`define VVS_DISCH_STEP   12'h002
// least charge step per cycle
`define VVS_CHG_MIN      12'h001
// oscillator cycles in one vertical pulse and divider ceiling
`define VVS_DIV_COUNT    4'h8
`define VVS_DIV_LAST     4'h7
// least oscillator period in clock cycles
`define VVS_OSC_MIN      16'h0010

`endif

// file: pkg/vvs_pkg.sv
// types shared by the vertical sync extractor modules
package vvs_pkg;

  // one video sample code
  typedef logic [7:0]  vvs_vid_t;
  // integrator level
  typedef logic [11:0] vvs_lvl_t;
  // oscillator period in clock cycles
  typedef logic [15:0] vvs_per_t;

  // vertical pulse latch state
  typedef enum logic [0:0]
  {
    VVS_IDLE  = 1'b0,
    VVS_PULSE = 1'b1
  } vvs_vstate_t;

endpackage

// file: rtl/vvs_osc_div.sv
// gated oscillator with a divide-by-eight that ends the vertical pulse
`timescale 1ns/10ps
`include "vvs_params.svh"
module vvs_osc_div
  import vvs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  vvs_osc_if.osc   osc
);

  vvs_per_t   cnt;        // clock cycles within one oscillator cycle
  logic [3:0] div;        // oscillator cycles seen
  vvs_per_t   next_cnt;
  logic [3:0] next_div;
  logic       next_tick;
  logic       next_done;

  ////////////////////////////////////////////////////////////////////
  // next values: the oscillator only runs while enabled
  always_comb
  begin
    next_cnt  = cnt;
    next_div  = div;
    next_tick = 1'b0;
    next_done = 1'b0;
    if (!osc.run)
    begin
      // stopped: restart from zero on the next enable
      next_cnt = '0;
      next_div = '0;
    end
    else if (cnt + 16'h0001 >= osc.period)
    begin
      // one oscillator cycle complete
      next_cnt  = '0;
      next_tick = 1'b1;
      if (div == `VVS_DIV_LAST)
      begin
        // eighth cycle: clear the latch
        next_done = 1'b1;
        next_div  = '0;
      end
      else
      begin
        next_div = div + 4'h1;
      end
    end
    else
    begin
      next_cnt = cnt + 16'h0001;
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt      <= '0;
      div      <= '0;
      osc.tick <= 1'b0;
      osc.done <= 1'b0;
    end
    else
    begin
      cnt      <= next_cnt;
      div      <= next_div;
      osc.tick <= next_tick;
      osc.done <= next_done;
    end
  end

endmodule

// file: rtl/vvs_vsync_extract.sv
// composite sync slicer and vertical sync extractor, top level
`timescale 1ns/10ps
`include "vvs_params.svh"
module vvs_vsync_extract
  import vvs_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire vvs_vid_t vid_in,
  input  wire vvs_vid_t rset_code,
  input  wire vvs_lvl_t serration_threshold,
  input  wire vvs_lvl_t default_threshold,
  output var  logic     csync_out,
  output var  logic     vsync_out,
  output var  logic     field_clk_out
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  vvs_osc_if osc ();        // latch to oscillator link

  vvs_vid_t    clamp;       // tracked sync tip level
  logic [15:0] leak_cnt;    // paces the clamp's upward leak
  logic        sync_q;      // internal sync, before output buffer
  vvs_lvl_t    integ;       // integrator level
  logic        det;         // serration detection flop
  logic        set_or_q;    // last OR output, for edge set
  vvs_vstate_t state;       // vertical pulse latch

  vvs_vid_t    next_clamp;
  logic [15:0] next_leak_cnt;
  logic        next_sync;
  vvs_lvl_t    next_integ;
  logic        next_det;
  vvs_vstate_t next_state;
  logic        next_field_clk;

  logic [8:0]  slice_sum;   // clamp plus offset, with carry
  vvs_vid_t    slice_lvl;   // comparator threshold
  logic        sync_now;    // sample is below the slice level
  logic        sync_end;    // trailing edge of a sync interval
  vvs_lvl_t    chg_step;    // charge per cycle from resistor code
  logic [12:0] chg_sum;     // charge with carry for saturation
  logic        dflt_cmp;    // default comparator output
  logic        set_or;      // detection OR default
  logic        set_rise;    // new set request for the latch

  ////////////////////////////////////////////////////////////////////
  // slicer: offset is fixed in codes, so independent of amplitude
  // clamp and slice
  always_comb
  begin
    slice_sum = {1'b0, clamp} + {1'b0, `VVS_SLICE_OFS};
    slice_lvl = slice_sum[8] ? 8'hFF : slice_sum[7:0];
    sync_now  = (vid_in < slice_lvl);
  end

  // clamp: drops at once to a lower tip, leaks up slowly otherwise
  always_comb
  begin
    next_clamp    = clamp;
    next_leak_cnt = leak_cnt + 16'h0001;
    if (vid_in < clamp)
    begin
      // fast charge onto the new tip
      next_clamp    = vid_in;
      next_leak_cnt = '0;
    end
    else if (leak_cnt >= `VVS_LEAK_CYC)
    begin
      // slow discharge toward the signal; stops at the tip itself
      next_leak_cnt = '0;
      if (vid_in > clamp)
        next_clamp = clamp + 8'h01;
    end
    next_sync = sync_now;
  end

  // slicer registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clamp     <= `VVS_CLAMP_RST;
      leak_cnt  <= '0;
      sync_q    <= 1'b0;
      csync_out <= 1'b0;
    end
    else
    begin
      clamp     <= next_clamp;
      leak_cnt  <= next_leak_cnt;
      sync_q    <= next_sync;
      csync_out <= next_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // integrator and comparators
  // short horizontal tips barely charge it before the long gaps drain
  // it; equalizing tips do the same, and only the wide vertical
  // pulse lets it climb; the step sizes trade detection margin for
  // immunity to a few noisy tips
  always_comb
  begin
    chg_step = {8'h00, ~rset_code[7:4]} + `VVS_CHG_MIN;
    chg_sum  = {1'b0, integ} + {1'b0, chg_step};
    if (sync_q)
      next_integ = chg_sum[12] ? `VVS_LVL_MAX : chg_sum[11:0];
    else if (integ > `VVS_DISCH_STEP)
      next_integ = integ - `VVS_DISCH_STEP;
    else
      next_integ = '0;
    // trailing edge of sync is the serration's rising video edge
    sync_end = sync_q & ~sync_now;
    next_det = sync_end ? (integ >= serration_threshold) : det;
    dflt_cmp = (integ >= default_threshold);
    set_or   = det | dflt_cmp;
    // edge set: a held set must not restart the pulse when it ends
    set_rise = set_or & ~set_or_q;
  end

  // integrator registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      integ    <= `VVS_LVL_RST;
      det      <= 1'b0;
      set_or_q <= 1'b0;
    end
    else
    begin
      integ    <= next_integ;
      det      <= next_det;
      set_or_q <= set_or;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // vertical pulse latch
  always_comb
  begin
    next_state     = state;
    next_field_clk = 1'b0;
    case (state)
      VVS_IDLE:
      begin
        if (set_rise)
        begin
          next_state     = VVS_PULSE;
          next_field_clk = 1'b1;
        end
      end
      VVS_PULSE:
      begin
        if (osc.done)
          next_state = VVS_IDLE;
      end
      default:
      begin
        next_state = VVS_IDLE;
      end
    endcase
  end

  // latch registers; output mirrors the latch
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= VVS_IDLE;
      vsync_out     <= 1'b0;
      field_clk_out <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      vsync_out     <= (next_state == VVS_PULSE);
      field_clk_out <= next_field_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // oscillator, running only while the latch is set
  // latch enables oscillator
  assign osc.run    = (state == VVS_PULSE);
  assign osc.period = {4'h0, rset_code, 4'h0} + `VVS_OSC_MIN;

  vvs_osc_div u_osc
  (
    .clk   (clk),
    .rst_n (rst_n),
    .osc   (osc)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  logic [3:0] ticks_seen;   // oscillator cycles within this pulse

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ticks_seen <= '0;
    else if (state != VVS_PULSE)
      ticks_seen <= '0;
    else if (osc.tick)
      ticks_seen <= ticks_seen + 4'h1;
  end

  a_csync_slice: assert property (
    @(posedge clk) disable iff (!rst_n)
    (vid_in < slice_lvl) |=> csync_out)
    else $error("csync missed a sample below the slice");

  a_clamp_tip: assert property (
    @(posedge clk) disable iff (!rst_n)
    (vid_in < clamp) |=> (clamp == $past(vid_in)))
    else $error("clamp did not follow a lower tip");

  a_integ_charge: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sync_q && !chg_sum[12]) |=> (integ == $past(chg_sum[11:0])))
    else $error("integrator did not charge during sync");

  a_integ_drain: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!sync_q && integ != 12'h000) |=> (integ < $past(integ)))
    else $error("integrator did not discharge outside sync");

  a_det_capture: assert property (
    @(posedge clk) disable iff (!rst_n)
    sync_end |=> (det == ($past(integ) >= $past(serration_threshold))))
    else $error("detection flop took the wrong compare");

  a_det_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    !sync_end |=> $stable(det))
    else $error("detection flop changed off the edge");

  a_latch_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!vsync_out && det && !set_or_q) |=> (vsync_out && field_clk_out))
    else $error("serration detection did not start the pulse");

  a_dflt_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == VVS_IDLE && dflt_cmp && !set_or_q) |=> vsync_out)
    else $error("default compare did not start the pulse");

  a_pulse_end: assert property (
    @(posedge clk) disable iff (!rst_n)
    osc.done |=> (!vsync_out && !field_clk_out))
    else $error("pulse outlived the eighth oscillator cycle");

  a_pulse_len: assert property (
    @(posedge clk) disable iff (!rst_n)
    osc.done |-> (ticks_seen == `VVS_DIV_LAST))
    else $error("pulse did not last eight oscillator cycles");

  // no ticks while the latch is clear
  a_osc_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    !osc.run |=> (!osc.tick && !osc.done))
    else $error("oscillator ticked while the latch was clear");

  // the field flop sees exactly one clock edge per pulse
  a_field_single: assert property (
    @(posedge clk) disable iff (!rst_n)
    field_clk_out |=> !field_clk_out)
    else $error("field clock stayed high");

  // ticks are spaced by the resistor-set period, never back to back
  a_tick_gap: assert property (
    @(posedge clk) disable iff (!rst_n)
    osc.tick |=> !osc.tick)
    else $error("oscillator ticked on two cycles in a row");

  // a set edge on an idle latch shows on the output one edge later
  a_vsync_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == VVS_IDLE && set_rise) |=> (vsync_out && field_clk_out))
    else $error("set edge did not start the vertical pulse");

endmodule
